// ===== src/tce_capture_psc.sv
// Capture prescaler: passes one edge in 1, 2, 4 or 8
module tce_capture_psc (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic [1:0] ratio,
  input  wire logic       edge_in,
  output logic            capture
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] last;

  // Terminal count for the selected ratio
  assign last = (ratio == tce_pkg::PSC_DIV1) ? 3'h0 :
                (ratio == tce_pkg::PSC_DIV2) ? 3'h1 :
                (ratio == tce_pkg::PSC_DIV4) ? 3'h3 : 3'h7;
  assign capture = enable & edge_in & (cnt_r >= last);
  assign cnt_nxt = !enable ? tce_pkg::PSC_RST :
                   !edge_in ? cnt_r :
                   capture ? tce_pkg::PSC_RST : 3'(cnt_r + 3'h1);

  // Event counter, held in reset while channel disabled
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cnt_r <= tce_pkg::PSC_RST;
    else cnt_r <= cnt_nxt;
  end
endmodule

// ===== src/tce_edge_sense.sv
// Per-channel input conditioning: synchroniser, polarity, edge detection
module tce_edge_sense (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       raw_in,
  input  wire logic       main_pol,
  input  wire logic       compl_pol,
  output logic            level_out,
  output logic            edge_out
);
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [1:0] pair;
  logic       rise;
  logic       fall;

  // Two-stage synchroniser, then one history flop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Edge and level selection by polarity pair
  assign pair = {compl_pol, main_pol};
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  assign level_out = (pair == 2'h1) ? ~sync2_r : sync2_r;
  assign edge_out  = (pair == 2'h0) ? rise :
                     (pair == 2'h1) ? fall :
                     (pair == 2'h3) ? (rise | fall) :
                     1'b0;                                // Reserved pair, no edges
endmodule

// ===== src/tce_pkg.sv
package tce_pkg;
  // Register byte offsets
  localparam logic [7:0] ENPOL_OFS = 8'h20;
  localparam logic [7:0] CNT_OFS   = 8'h24;
  // Field positions inside the enable register, channel n at 4*n
  localparam int EN_POS    = 0;
  localparam int MPOL_POS  = 1;
  localparam int CPOL_POS  = 3;
  localparam int CH_STRIDE = 4;
  // Writable bits of the enable register: 15,13,12,11,9,8,7,5,4,3,1,0
  localparam logic [31:0] ENPOL_WMASK = 32'h0000_BBBB;
  localparam logic [31:0] ENPOL_RST   = 32'h0000_0000;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [2:0]  PSC_RST     = 3'h0;
  // Capture prescaler ratio codes
  localparam logic [1:0] PSC_DIV1 = 2'h0;
  localparam logic [1:0] PSC_DIV2 = 2'h1;
  localparam logic [1:0] PSC_DIV4 = 2'h2;
  localparam logic [1:0] PSC_DIV8 = 2'h3;
  // Input edge sense from {compl, main} polarity
  typedef enum logic [1:0] {
    TCE_SENSE_RISE,
    TCE_SENSE_FALL,
    TCE_SENSE_RSVD,
    TCE_SENSE_BOTH
  } tce_sense_e;
endpackage

// ===== src/tce_top.sv
// Notes on behaviour
// - Output channel drives pin only when enabled
// - Disabled output forced 0, enable low
// - Capture into register only while enabled
// - Main polarity 0 high, 1 low
// - Complementary polarity 0 high, 1 low
// - Pair 00: rising edges, uninverted level
// - Pair 01: falling edges, inverted level
// - Pair 11: both edges, uninverted level
// - Channel 2..4 enables at bits 4,8,12
// - Channel polarities at 5,9,13 and 7,11,15
// - Reserved enable bits reset and read zero
// - Counter readable and writable, resets zero
// - Prescaler held reset while channel disabled
module tce_top #(
  parameter int NCH = 4,
  parameter int CW  = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  input  wire logic             cnt_tick,
  input  wire logic             cnt_run,
  input  wire logic [NCH-1:0]   ch_is_input,
  input  wire logic [NCH*2-1:0] capture_ratio,
  input  wire logic [NCH-1:0]   channel_reference_wave,
  input  wire logic [NCH-1:0]   filtered_input_pin,
  output logic [NCH-1:0]        channel_output,
  output logic [NCH-1:0]        channel_output_enable,
  output logic                  ch1_complementary_output,
  output logic [NCH-1:0]        input_level,
  output logic [NCH-1:0]        input_edge,
  output logic [NCH-1:0]        capture_event,
  output logic [NCH*CW-1:0]     capture_value
);
  logic [31:0]       enpol_r;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic [NCH-1:0]    enable;
  logic [NCH-1:0]    main_pol;
  logic [NCH-1:0]    compl_pol;
  logic [NCH-1:0]    out_nxt;
  logic [NCH-1:0]    oe_nxt;
  logic [NCH-1:0]    out_r;
  logic [NCH-1:0]    oe_r;
  logic              compl_r;
  logic              wr_enpol;
  logic              wr_cnt;
  logic              rd_enpol;
  logic              rd_cnt;

  // Address decode
  assign wr_enpol = reg_wr & (reg_addr == tce_pkg::ENPOL_OFS);
  assign wr_cnt   = reg_wr & (reg_addr == tce_pkg::CNT_OFS);
  assign rd_enpol = reg_rd & (reg_addr == tce_pkg::ENPOL_OFS);
  assign rd_cnt   = reg_rd & (reg_addr == tce_pkg::CNT_OFS);

  // Field extraction per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_fld
      assign enable[g]    = enpol_r[g*tce_pkg::CH_STRIDE + tce_pkg::EN_POS];
      assign main_pol[g]  = enpol_r[g*tce_pkg::CH_STRIDE + tce_pkg::MPOL_POS];
      assign compl_pol[g] = enpol_r[g*tce_pkg::CH_STRIDE + tce_pkg::CPOL_POS];
    end
  endgenerate

  // Enable and polarity register, reserved bits masked out
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) enpol_r <= tce_pkg::ENPOL_RST;
    else if (wr_enpol) enpol_r <= reg_wdata & tce_pkg::ENPOL_WMASK;
  end

  // Counter: a write is taken now and counting resumes from it
  assign cnt_nxt = wr_cnt ? reg_wdata[CW-1:0] :
                   (cnt_tick & cnt_run) ? CW'(cnt_r + 1'b1) : cnt_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cnt_r <= tce_pkg::CNT_RST;
    else cnt_r <= cnt_nxt;
  end

  // Read mux, unmapped addresses read zero
  assign rdata_nxt = rd_enpol ? enpol_r :
                     rd_cnt ? {{(32-CW){1'b0}}, cnt_r} : 32'h0000_0000;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rdata_r <= 32'h0000_0000;
    else rdata_r <= rdata_nxt;
  end
  assign reg_rdata = rdata_r;

  // Output stage: gate and invert the reference waveform
  assign out_nxt = enable & ~ch_is_input & (channel_reference_wave ^ main_pol);
  assign oe_nxt  = enable & ~ch_is_input;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_r   <= '0;
      oe_r    <= '0;
      compl_r <= 1'b0;
    end else begin
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
      compl_r <= enable[0] & ~ch_is_input[0] & (~channel_reference_wave[0] ^ compl_pol[0]);
    end
  end
  assign channel_output           = out_r;
  assign channel_output_enable    = oe_r;
  assign ch1_complementary_output = compl_r;

  // Input path per channel: condition, prescale, capture
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic          edge_w;
      logic          cap_w;
      logic [CW-1:0] cap_ch_r;

      tce_edge_sense u_sense (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .raw_in    (filtered_input_pin[g]),
        .main_pol  (main_pol[g]),
        .compl_pol (compl_pol[g]),
        .level_out (input_level[g]),
        .edge_out  (edge_w)
      );

      tce_capture_psc u_psc (
        .mclk    (mclk),
        .reset_n (reset_n),
        .enable  (enable[g] & ch_is_input[g]),
        .ratio   (capture_ratio[g*2 +: 2]),
        .edge_in (edge_w),
        .capture (cap_w)
      );

      assign input_edge[g]    = edge_w;
      assign capture_event[g] = cap_w;

      // Counter snapshot, only while capture is enabled; one register per channel
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) cap_ch_r <= tce_pkg::CNT_RST;
        else if (cap_w) cap_ch_r <= cnt_r;
      end
      assign capture_value[g*CW +: CW] = cap_ch_r;
    end
  endgenerate
endmodule

// ===== tb/tb.sv
// Register, output and capture tests of the channel block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] cfg;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        cnt_tick = 1'b0;
  logic        cnt_run = 1'b0;
  logic        rd_d = 1'b0;
  logic        cap_d = 1'b0;
  logic [3:0]  ch_is_input = 4'h0;
  logic [3:0]  ref_wave = 4'h0;
  logic [3:0]  pin = 4'h0;
  logic [7:0]  ratio = 8'h00;
  logic [3:0]  cap_ev;
  logic [63:0] cap_val;
  logic [31:0] rq[$];
  logic [31:0] cq[$];
  logic [31:0] cfgs[4] = '{32'h1, 32'h3, 32'hB, 32'h0};
  int          ncap[4] = '{1, 1, 2, 0};
  integer      seed = 32'h5571;
  integer      mismatches = 0;
  integer      check_count = 0;
  tce_top i_tce_top (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cnt_tick(cnt_tick), .cnt_run(cnt_run),
    .ch_is_input(ch_is_input), .capture_ratio(ratio), .channel_reference_wave(ref_wave),
    .filtered_input_pin(pin), .channel_output(), .channel_output_enable(), .ch1_complementary_output(),
    .input_level(), .input_edge(), .capture_event(cap_ev), .capture_value(cap_val));
  // Clock
  initial forever #2 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge mclk);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task close_out;
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Random reference waveform
  always @(posedge mclk) ref_wave <= 4'($random(seed));
  // Results against the oldest note
  always @(posedge mclk) begin
    if (rd_d) chk("rdata", rq.size() > 0 ? rq.pop_front() : 'x, reg_rdata);
    if (cap_d) chk("capture", cq.size() > 0 ? cq.pop_front() : 'x, {16'h0, cap_val[15:0]});
    rd_d <= reg_rd;
    cap_d <= cap_ev[0];
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    wr(8'h20, 32'h0000_BBBB);
    rd(8'h20, 32'h0000_BBBB);
    rd(8'h28, 32'h0);
    repeat (12) begin
      cfg = $random(seed) & 32'h0000_BBBB;
      cfg = cfg | ((cfg >> 2) & 32'h2222);
      ch_is_input <= 4'($random(seed));
      wr(8'h20, cfg);
      rd(8'h20, cfg);
      idle(3);
    end
    wr(8'h24, 32'h0000_1234);
    rd(8'h24, 32'h0000_1234);
    cnt_tick <= 1'b1;
    cnt_run <= 1'b1;
    idle(1);
    cnt_run <= 1'b0;
    rd(8'h24, 32'h0000_1235);
    ch_is_input <= 4'hF;
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, cfgs[i] & 32'hFFFF_FFFE);
      idle(4);
      wr(8'h20, cfgs[i]);
      repeat (ncap[i]) cq.push_back(32'h0000_1235);
      idle(2);
      pin <= 4'hF;
      idle(8);
      pin <= 4'h0;
      idle(8);
    end
    // Divide by 2: second rise captures, a disable clears the odd third rise
    ratio <= 8'h01;
    wr(8'h20, 32'h0000_0001);
    cq.push_back(32'h0000_1235);
    repeat (3) begin
      pin <= 4'hF;
      idle(8);
      pin <= 4'h0;
      idle(8);
    end
    wr(8'h20, 32'h0000_0000);
    wr(8'h20, 32'h0000_0001);
    pin <= 4'hF;
    idle(8);
    pin <= 4'h0;
    idle(8);
    idle(4);
    chk("leftover", 32'h0, 32'(rq.size() + cq.size()));
    close_out();
  end
  // Watchdog
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
endmodule

// ===== tb/tce_checker.sv
// Port-level checks of the channel enable and polarity block
module tce_checker #(
  parameter int NCH = 4,
  parameter int CW  = 16
) (
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic [NCH-1:0]    ch_is_input,
  input wire logic [NCH-1:0]    channel_reference_wave,
  input wire logic [NCH-1:0]    filtered_input_pin,
  input wire logic [NCH-1:0]    channel_output,
  input wire logic [NCH-1:0]    channel_output_enable,
  input wire logic              ch1_complementary_output,
  input wire logic [NCH-1:0]    input_edge,
  input wire logic [NCH-1:0]    capture_event,
  input wire logic [NCH*CW-1:0] capture_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0]    enpol_r;
  logic [NCH-1:0] en_w;
  logic [NCH-1:0] mpol_w;
  logic [NCH-1:0] cpol_w;
  logic [NCH-1:0] oe_w;
  logic [1:0]     pair_w;
  // Shadow of the enable register, writable bits only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) enpol_r <= 32'h0;
    else if (reg_wr && reg_addr == 8'h20) enpol_r <= reg_wdata & 32'h0000_BBBB;
  end
  // Per-channel fields
  assign en_w   = {enpol_r[12], enpol_r[8], enpol_r[4], enpol_r[0]};
  assign mpol_w = {enpol_r[13], enpol_r[9], enpol_r[5], enpol_r[1]};
  assign cpol_w = {enpol_r[15], enpol_r[11], enpol_r[7], enpol_r[3]};
  assign oe_w   = en_w & ~ch_is_input;
  assign pair_w = {enpol_r[3], enpol_r[1]};
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_OE: assert property (channel_output_enable == $past(oe_w))
    else $error("output enable off");
  AST_OUT: assert property (channel_output == $past((channel_reference_wave ^ mpol_w) & oe_w))
    else $error("channel output wrong");
  AST_COMPL: assert property (!$past(ch_is_input[0]) |->
    ch1_complementary_output == $past((~channel_reference_wave[0] ^ cpol_w[0]) & en_w[0]))
    else $error("complementary output wrong");
  AST_CAP_EN: assert property ((capture_event & ~en_w & ~$past(en_w)) == 4'h0)
    else $error("capture while disabled");
  AST_CAP_HOLD: assert property (!capture_event[0] |=> $stable(capture_value[15:0]))
    else $error("capture value moved");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  AST_RD_ENPOL: assert property ($past(reg_rd && reg_addr == 8'h20) |-> reg_rdata == $past(enpol_r))
    else $error("enable register read wrong");
  AST_RISE: assert property ($rose(filtered_input_pin[0]) ##0 (pair_w == 2'b00)[*3] |-> ##[0:2] input_edge[0])
    else $error("rising edge missed");
  AST_FALL: assert property ($fell(filtered_input_pin[0]) ##0 (pair_w == 2'b01)[*3] |-> ##[0:2] input_edge[0])
    else $error("falling edge missed");
  AST_BOTH: assert property ($changed(filtered_input_pin[0]) ##0 (pair_w == 2'b11)[*3] |-> ##[0:2] input_edge[0])
    else $error("edge missed");
  // Main scenarios reached
  cover property (capture_event[0]);
  cover property (|channel_output_enable);
  cover property ($past(reg_rd) && reg_rdata != 32'h0);
endmodule
bind tce_top tce_checker #(.NCH(NCH), .CW(CW)) i_tce_checker (.*);
